// ==== inc/xmp_pkg.sv ====
// package: register map, field layout and timing constants of the external memory port
package xmp_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CONFIG  = 4'h0;
  localparam logic [3:0] ADDR_PAGE    = 4'h4;
  localparam logic [3:0] ADDR_TIMING  = 4'h8;
  localparam logic [3:0] ADDR_STATUS  = 4'hc;

  // device offset of the configuration register, kept for reference
  localparam logic [7:0] CONFIG_DEV_OFFSET = 8'ha3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CONFIG_RESET = 8'h03;
  localparam logic [7:0] PAGE_RESET   = 8'h00;
  localparam logic [7:0] TIMING_RESET = 8'hff;

  // ---------------------------------------------------------------
  // configuration fields
  // ---------------------------------------------------------------
  localparam int         CFG_PORT_BIT  = 5;
  localparam int         CFG_MUX_BIT   = 4;
  localparam int         CFG_MODE_HI   = 3;
  localparam int         CFG_MODE_LO   = 2;
  localparam int         CFG_ALE_HI    = 1;
  localparam int         CFG_ALE_LO    = 0;
  localparam logic [7:0] CFG_WR_MASK   = 8'h3f;

  // timing fields
  localparam int TM_SETUP_HI = 7;
  localparam int TM_SETUP_LO = 6;
  localparam int TM_PULSE_HI = 5;
  localparam int TM_PULSE_LO = 2;
  localparam int TM_HOLD_HI  = 1;
  localparam int TM_HOLD_LO  = 0;

  // ---------------------------------------------------------------
  // operating modes
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_ON_CHIP   = 2'h0;
  localparam logic [1:0] MODE_SPLIT     = 2'h1;
  localparam logic [1:0] MODE_SPLIT_BANK= 2'h2;
  localparam logic [1:0] MODE_OFF_CHIP  = 2'h3;

  // on-chip data ram size and address width
  localparam int          RAM_BYTES = 8192;
  localparam int          RAM_AW    = 13;
  localparam logic [15:0] RAM_LIMIT = 16'h2000;

  // fixed overhead of an off-chip move, in system clocks
  localparam int          MOVE_OVERHEAD = 4;
  localparam logic [4:0]  GAP_CYCLES    = 5'h1;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_SETUP = 8'h02,
    ST_ALEH  = 8'h04,
    ST_ALEL  = 8'h08,
    ST_PULSE = 8'h10,
    ST_HOLD  = 8'h20,
    ST_GAP   = 8'h40,
    ST_RAM   = 8'h80
  } xmp_state_type;

endpackage

// ==== rtl/xmp_ram.sv ====
// on-chip data ram with registered read data
`timescale 1ns/1ps
module xmp_ram #(
  parameter int AW = 13,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          en,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata_q
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (en && we) begin
      mem[addr] <= wdata;
    end
    if (en) begin
      rdata_q <= mem[addr];
    end
  end
endmodule

// ==== rtl/xmp_port.sv ====
// external data memory port: config registers, address routing and strobe sequencer
// Function
// - port select chooses lower or upper groups
// - multiplex bit shares or separates address pins
// - mode 00 all on-chip, wraps 8k
// - 8-bit address page:index, 16-bit pointer
// - split modes: below 8k on-chip, else off
// - mode 01 8-bit leaves high address undriven
// - mode 10 8-bit drives page and index
// - split 16-bit uses pointer, drives 16 bits
// - mode 11 all off-chip, ram hidden
// - mode 11 8-bit ignores page, high undriven
// - latch width code sets 1-4 clocks
// - latch width ignored in separate-pin mode
// - phase one: latch high, low address out
// - latch fall, data owns pins at strobe
// - separate mode has no latch phase
// - setup, hold, strobe, latch programmable
// - move takes 4 plus parameters, min 5
// - multiplexed adds two latch widths, min 7
// - setup and hold reset to longest
// - top two config bits read zero
// - 8 kB on-chip ram is default target
// - port drives pins only during move
// - input pins undriven during off-chip read strobe
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module xmp_port
  import xmp_pkg::*;
#(
  parameter int RAM_AW_P = 13
) (
  input  wire logic        clk,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // move request from the core
  input  wire logic        move_req,
  input  wire logic        move_write,
  input  wire logic        move_short,
  input  wire logic [15:0] move_pointer,
  input  wire logic [7:0]  move_index,
  input  wire logic [7:0]  move_wdata,
  output logic             move_done,
  output logic      [7:0]  move_rdata_q,
  // external pins
  output logic             port_group_q,
  output logic             pins_claimed,
  output logic      [15:0] addr_out_q,
  output logic             addr_hi_oe,
  output logic             addr_lo_oe,
  output logic      [7:0]  data_out_q,
  output logic             data_oe,
  input  wire logic [7:0]  data_in,
  output logic             latch_strobe_q,
  output logic             read_strobe_n_q,
  output logic             write_strobe_n_q
);
  if (RAM_AW_P != RAM_AW) $error("ram address width must be 13");

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [5:0]    cfg_q;
  logic [7:0]    page_q;
  logic [7:0]    timing_q;
  xmp_state_type state_q;
  logic [4:0]    cnt_q;
  logic          wr_q;
  logic          short_q;
  logic [15:0]   eff_q;
  logic [7:0]    wdata_q;
  logic [7:0]    data_s1_q;
  logic [7:0]    data_s2_q;
  logic [7:0]    ram_rdata;

  logic       mux_mode;
  logic [1:0] op_mode;
  logic [1:0] ale_code;
  logic [1:0] setup_code;
  logic [3:0] pulse_code;
  logic [1:0] hold_code;
  assign mux_mode   = ~cfg_q[CFG_MUX_BIT];
  assign op_mode    = cfg_q[CFG_MODE_HI:CFG_MODE_LO];
  assign ale_code   = cfg_q[CFG_ALE_HI:CFG_ALE_LO];
  assign setup_code = timing_q[TM_SETUP_HI:TM_SETUP_LO];
  assign pulse_code = timing_q[TM_PULSE_HI:TM_PULSE_LO];
  assign hold_code  = timing_q[TM_HOLD_HI:TM_HOLD_LO];
  assign port_group_q = cfg_q[CFG_PORT_BIT];

  // ---------------------------------------------------------------
  // avalon slave: one wait cycle on reads, writes immediate
  // ---------------------------------------------------------------
  logic rd_ack_q;
  assign avs_waitrequest = avs_read & ~rd_ack_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_ack_q <= 1'b0;
    end else begin
      rd_ack_q <= avs_read & ~rd_ack_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_q    <= CONFIG_RESET[5:0];
      page_q   <= PAGE_RESET;
      timing_q <= TIMING_RESET;
    end else if (avs_write && avs_byteenable[0]) begin
      if (avs_address == ADDR_CONFIG) begin
        cfg_q <= avs_writedata[5:0] & CFG_WR_MASK[5:0];
      end else if (avs_address == ADDR_PAGE) begin
        page_q <= avs_writedata[7:0];
      end else if (avs_address == ADDR_TIMING) begin
        timing_q <= avs_writedata[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !rd_ack_q) begin
      if (avs_address == ADDR_CONFIG) begin
        avs_readdata <= {26'h0, cfg_q};
      end else if (avs_address == ADDR_PAGE) begin
        avs_readdata <= {24'h0, page_q};
      end else if (avs_address == ADDR_TIMING) begin
        avs_readdata <= {24'h0, timing_q};
      end else if (avs_address == ADDR_STATUS) begin
        avs_readdata <= {23'h0, state_q != ST_IDLE, state_q};
      end else begin
        avs_readdata <= 32'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // address routing
  // ---------------------------------------------------------------
  logic [15:0] eff_addr;
  logic        go_ram;
  always_comb begin
    eff_addr = move_short ? {page_q, move_index} : move_pointer;
    if (op_mode == MODE_ON_CHIP) begin
      go_ram = 1'b1;
    end else if (op_mode == MODE_OFF_CHIP) begin
      go_ram = 1'b0;
    end else begin
      go_ram = eff_addr < RAM_LIMIT;
    end
  end

  // high address byte driven unless 8-bit move in mode 01 or 11
  logic hi_driven;
  assign hi_driven = ~short_q | (op_mode == MODE_SPLIT_BANK);

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  logic [4:0] ale_len;
  logic [4:0] pulse_len;
  assign ale_len   = {3'h0, ale_code} + 5'h1;
  assign pulse_len = {1'b0, pulse_code} + 5'h1;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q   <= 5'h0;
      wr_q    <= 1'b0;
      short_q <= 1'b0;
      eff_q   <= 16'h0;
      wdata_q <= 8'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (move_req) begin
            wr_q    <= move_write;
            short_q <= move_short;
            wdata_q <= move_wdata;
            eff_q   <= eff_addr;
            cnt_q   <= {3'h0, setup_code};
            state_q <= go_ram ? ST_RAM : ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (cnt_q == 5'h0) begin
            if (mux_mode) begin
              cnt_q   <= ale_len - 5'h1;
              state_q <= ST_ALEH;
            end else begin
              cnt_q   <= pulse_len - 5'h1;
              state_q <= ST_PULSE;
            end
          end else begin
            cnt_q <= cnt_q - 5'h1;
          end
        end
        ST_ALEH: begin
          if (cnt_q == 5'h0) begin
            cnt_q   <= ale_len - 5'h1;
            state_q <= ST_ALEL;
          end else begin
            cnt_q <= cnt_q - 5'h1;
          end
        end
        ST_ALEL: begin
          if (cnt_q == 5'h0) begin
            cnt_q   <= pulse_len - 5'h1;
            state_q <= ST_PULSE;
          end else begin
            cnt_q <= cnt_q - 5'h1;
          end
        end
        ST_PULSE: begin
          if (cnt_q == 5'h0) begin
            cnt_q   <= {3'h0, hold_code};
            state_q <= ST_HOLD;
          end else begin
            cnt_q <= cnt_q - 5'h1;
          end
        end
        ST_HOLD: begin
          if (cnt_q == 5'h0) begin
            cnt_q   <= GAP_CYCLES;
            state_q <= ST_GAP;
          end else begin
            cnt_q <= cnt_q - 5'h1;
          end
        end
        ST_GAP: begin
          if (cnt_q == 5'h0) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 5'h1;
          end
        end
        ST_RAM:  state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // on-chip ram access, address wraps modulo 8k
  // ---------------------------------------------------------------
  xmp_ram #(
    .AW (RAM_AW),
    .DW (8)
  ) u_ram (
    .clk     (clk),
    .en      (state_q == ST_IDLE && move_req && go_ram),
    .we      (move_write),
    .addr    (eff_addr[RAM_AW-1:0]),
    .wdata   (move_wdata),
    .rdata_q (ram_rdata)
  );

  // ---------------------------------------------------------------
  // pins; the input path is synchronised since it is asynchronous
  // ---------------------------------------------------------------
  logic ext_active;
  assign ext_active   = state_q inside {ST_SETUP, ST_ALEH, ST_ALEL, ST_PULSE, ST_HOLD};
  assign pins_claimed = ext_active;
  assign addr_hi_oe   = ext_active & hi_driven;
  assign addr_lo_oe   = ext_active & ~mux_mode;
  // shared pins carry the low address, then write data; released during reads
  assign data_oe      = ext_active & (wr_q | (mux_mode & (state_q inside {ST_SETUP, ST_ALEH})));
  logic strobe_next;
  assign strobe_next = (state_q == ST_PULSE && cnt_q != 5'h0) ||
                       (cnt_q == 5'h0 && (state_q == ST_ALEL || (state_q == ST_SETUP && !mux_mode)));

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_out_q       <= 16'h0;
      data_out_q       <= 8'h0;
      latch_strobe_q   <= 1'b0;
      read_strobe_n_q  <= 1'b1;
      write_strobe_n_q <= 1'b1;
      data_s1_q        <= 8'h0;
      data_s2_q        <= 8'h0;
    end else begin
      data_s1_q <= data_in;
      data_s2_q <= data_s1_q;
      addr_out_q <= eff_q;
      data_out_q <= (mux_mode && (state_q == ST_SETUP || state_q == ST_ALEH)) ? eff_q[7:0] : wdata_q;
      latch_strobe_q   <= (state_q == ST_SETUP && cnt_q == 5'h0 && mux_mode) ||
                          (state_q == ST_ALEH && cnt_q != 5'h0);
      read_strobe_n_q  <= ~(!wr_q && strobe_next);
      write_strobe_n_q <= ~(wr_q && strobe_next);
    end
  end

  // read data: ram answers one cycle after the take; pin bytes come late through the synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      move_rdata_q <= 8'h0;
    end else if (state_q == ST_RAM && !wr_q) begin
      move_rdata_q <= ram_rdata;
    end else if (state_q == ST_GAP && cnt_q == 5'h0 && !wr_q) begin
      move_rdata_q <= data_s2_q;
    end
  end

  assign move_done = (state_q == ST_RAM) || (state_q == ST_GAP && cnt_q == 5'h0);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_ram_quiet;
    @(posedge clk) disable iff (rst)
      state_q == ST_RAM |=> read_strobe_n_q && write_strobe_n_q && !latch_strobe_q && !pins_claimed;
  endproperty
  a_ram_quiet: assert property (p_ram_quiet) else $error("strobe during on-chip move");

  sequence s_mux_claim;
    $rose(pins_claimed) && mux_mode;
  endsequence
  property p_min_mux;
    @(posedge clk) disable iff (rst)
      s_mux_claim |-> pins_claimed [*5];
  endproperty
  a_min_mux: assert property (p_min_mux) else $error("multiplexed move too short");

  property p_mode0;
    @(posedge clk) disable iff (rst)
      state_q == ST_IDLE && move_req && op_mode == MODE_ON_CHIP |=> state_q == ST_RAM;
  endproperty
  a_mode0: assert property (p_mode0) else $error("mode 00 move left chip");

  property p_mode3;
    @(posedge clk) disable iff (rst)
      state_q == ST_IDLE && move_req && op_mode == MODE_OFF_CHIP |=> state_q == ST_SETUP;
  endproperty
  a_mode3: assert property (p_mode3) else $error("mode 11 move stayed on chip");

  property p_sep_no_latch;
    @(posedge clk) disable iff (rst)
      !mux_mode |-> !(state_q inside {ST_ALEH, ST_ALEL});
  endproperty
  a_sep_no_latch: assert property (p_sep_no_latch) else $error("latch phase in separate mode");

  property p_read_release;
    @(posedge clk) disable iff (rst)
      !read_strobe_n_q |-> !data_oe;
  endproperty
  a_read_release: assert property (p_read_release) else $error("data driven during read");

  property p_hi_bank;
    @(posedge clk) disable iff (rst)
      ext_active && short_q && op_mode != MODE_SPLIT_BANK |-> !addr_hi_oe;
  endproperty
  a_hi_bank: assert property (p_hi_bank) else $error("high address driven");

  property p_split;
    @(posedge clk) disable iff (rst)
      state_q == ST_IDLE && move_req && op_mode == MODE_SPLIT_BANK && eff_addr >= RAM_LIMIT |=> ext_active;
  endproperty
  a_split: assert property (p_split) else $error("split high address not off-chip");
endmodule

// ==== verif/xmp_ext_mem.sv ====
// partner: asynchronous byte memory with an address latch on the port pins
`timescale 1ns/1ps
module xmp_ext_mem #(
  parameter logic [7:0] PARK = 8'hff
) (
  input  wire logic        clk,
  input  wire logic        mux_mode,
  input  wire logic        slow,
  input  wire logic        pins_claimed,
  input  wire logic [15:0] addr_out_q,
  input  wire logic        addr_hi_oe,
  input  wire logic        addr_lo_oe,
  input  wire logic [7:0]  data_out_q,
  input  wire logic        data_oe,
  input  wire logic        latch_strobe_q,
  input  wire logic        read_strobe_n_q,
  input  wire logic        write_strobe_n_q,
  output logic      [7:0]  data_in
);
  // ---------------------------------------------------------------
  // storage and address decode
  // ---------------------------------------------------------------
  logic [7:0]  mem [65536];
  logic [7:0]  lat_q = 8'h00;
  logic [7:0]  lo;
  logic [7:0]  dpins;
  logic [7:0]  wd_q = 8'h00;
  logic [7:0]  inv_q = 8'h00;
  logic [15:0] a;
  logic [15:0] wa_q = 16'h0000;
  logic [15:0] ra_q = 16'h0000;
  logic        wr_q = 1'b0;
  logic        drv;
  int          rd_n = 0;
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // parked pins are pulled high, so an undriven byte reads as PARK
  assign lo = addr_lo_oe ? addr_out_q[7:0] : PARK;
  // the latch sits on the shared data pins, not on the separate low address pins
  assign dpins = data_oe ? data_out_q : PARK;
  assign a  = {addr_hi_oe ? addr_out_q[15:8] : PARK, mux_mode ? lat_q : lo};
  always @(*) begin
    if (latch_strobe_q) begin
      lat_q = dpins;
    end
  end
  // ---------------------------------------------------------------
  // strobes
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (!write_strobe_n_q) begin
      wd_q <= dpins;
      wa_q <= a;
    end
    if (write_strobe_n_q && wr_q) begin
      mem[wa_q] <= wd_q;
    end
    wr_q <= !write_strobe_n_q;
    if (!read_strobe_n_q) begin
      rd_n <= rd_n + 1;
      ra_q <= a;
    end else if (!pins_claimed) begin
      rd_n <= 0;
    end
    inv_q <= ~data_in;
  end
  // a slow part needs two strobe cycles; released pins show the inverse, not the old byte
  assign drv     = pins_claimed && (!read_strobe_n_q || rd_n > 0) && (!slow || rd_n >= 2);
  assign data_in = drv ? mem[read_strobe_n_q ? ra_q : a] : inv_q;
endmodule

// ==== verif/tb_external_data_memory_port_config.sv ====
// testbench: registers, move routing and strobe timing of the external memory port
`timescale 1ns/1ps
module tb_external_data_memory_port_config;
  import xmp_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h1;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        move_req = 1'b0;
  logic        move_write = 1'b0;
  logic        move_short = 1'b0;
  logic [15:0] move_pointer = 16'h0;
  logic [7:0]  move_index = 8'h0;
  logic [7:0]  move_wdata = 8'h0;
  logic        move_done;
  logic [7:0]  move_rdata_q;
  logic        port_group_q;
  logic        pins_claimed;
  logic [15:0] addr_out_q;
  logic        addr_hi_oe;
  logic        addr_lo_oe;
  logic [7:0]  data_out_q;
  logic        data_oe;
  logic [7:0]  data_in;
  logic        latch_strobe_q;
  logic        read_strobe_n_q;
  logic        write_strobe_n_q;
  logic        mux_mode = 1'b1;
  logic        slow = 1'b0;
  logic [7:0]  q;
  int          n;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          n_ale, n_rd, n_wr, n_claim, n_hi, n_bad;

  initial begin
    forever #10 clk = ~clk;
  end

  xmp_port dut_u (
    .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .move_req, .move_write, .move_short, .move_pointer, .move_index, .move_wdata,
    .move_done, .move_rdata_q, .port_group_q, .pins_claimed, .addr_out_q, .addr_hi_oe, .addr_lo_oe,
    .data_out_q, .data_oe, .data_in, .latch_strobe_q, .read_strobe_n_q, .write_strobe_n_q
  );
  xmp_ext_mem mem_u (
    .clk, .mux_mode, .slow, .pins_claimed, .addr_out_q, .addr_hi_oe, .addr_lo_oe, .data_out_q,
    .data_oe, .latch_strobe_q, .read_strobe_n_q, .write_strobe_n_q, .data_in
  );

  // pin activity per move, counted mid-cycle where everything has settled
  always @(negedge clk) begin
    n_ale   += (latch_strobe_q === 1'b1);
    n_rd    += (read_strobe_n_q === 1'b0);
    n_wr    += (write_strobe_n_q === 1'b0);
    n_claim += (pins_claimed === 1'b1);
    n_hi    += (addr_hi_oe === 1'b1);
    n_bad   += (data_oe === 1'b1 && read_strobe_n_q === 1'b0);
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= ~w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && k < 50) begin
      @(posedge clk);
      k++;
    end
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (k == 50) begin
      n_mismatch++;
      print_verdict();
    end
  endtask

  task mv(input logic w, input logic s, input logic [15:0] p, input logic [7:0] ix, input logic [7:0] d);
    @(posedge clk);
    move_write <= w;
    move_short <= s;
    move_pointer <= p;
    move_index <= ix;
    move_wdata <= d;
    move_req <= 1'b1;
    {n_ale, n_rd, n_wr, n_claim, n_hi, n_bad} = '0;
    n = 0;
    // the first falling edge comes before the edge that takes the request
    @(negedge clk);
    do begin
      @(negedge clk);
      n++;
    end while (move_done !== 1'b1 && n < 200);
    if (n == 200) begin
      n_mismatch++;
      print_verdict();
    end
    @(posedge clk);
    move_req <= 1'b0;
    @(negedge clk);
    q = move_rdata_q;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_regs;
    bus(0, ADDR_CONFIG, 8'h00);
    chk("config reset", 8'h03, q);
    bus(0, ADDR_TIMING, 8'h00);
    chk("timing reset", 8'hff, q);
    bus(1, ADDR_CONFIG, 8'hff);
    @(negedge clk);
    chk("port group upper", 1'b1, port_group_q);
    bus(0, ADDR_CONFIG, 8'h00);
    chk("config top bits", 8'h3f, q);
    bus(1, ADDR_CONFIG, 8'h1f);
    @(negedge clk);
    chk("port group lower", 1'b0, port_group_q);
    bus(0, 4'h2, 8'h00);
    chk("unmapped read", 8'h00, q);
  endtask

  task t_onchip;
    bus(1, ADDR_CONFIG, 8'h00);
    mv(1, 0, 16'h4005, 8'h00, 8'ha5);
    chk("on-chip cycles", 1, n);
    chk("on-chip pin activity", 0, n_rd + n_wr + n_ale + n_claim);
    mv(0, 0, 16'h0005, 8'h00, 8'h00);
    chk("wrapped read", 8'ha5, q);
    bus(1, ADDR_PAGE, 8'h20);
    mv(0, 1, 16'h0000, 8'h05, 8'h00);
    chk("page index read", 8'ha5, q);
  endtask

  task t_bank;
    mux_mode <= 1'b0;
    bus(1, ADDR_CONFIG, 8'h1b);
    bus(1, ADDR_TIMING, 8'h00);
    mv(1, 0, 16'h2100, 8'h00, 8'h44);
    chk("separate cycles", 5, n);
    chk("separate latch", 0, n_ale);
    bus(1, ADDR_CONFIG, 8'h18);
    bus(1, ADDR_PAGE, 8'h35);
    mv(1, 1, 16'h0000, 8'h12, 8'h3c);
    chk("bank write data", 8'h3c, mem_u.mem[16'h3512]);
    chk("bank high pins", 1'b1, n_hi != 0);
    chk("write strobe width", 1, n_wr);
    mv(1, 0, 16'h1fff, 8'h00, 8'h11);
    chk("below boundary on chip", 0, n_claim);
    mv(1, 0, 16'h2000, 8'h00, 8'h77);
    chk("pointer write", 8'h77, mem_u.mem[16'h2000]);
    chk("pointer high pins", 1'b1, n_hi != 0);
    // longest timing again, with a slow part to prove the wait is the strobe's, not the memory's
    bus(1, ADDR_TIMING, 8'hff);
    slow <= 1'b1;
    mv(0, 0, 16'h3512, 8'h00, 8'h00);
    chk("slow read data", 8'h3c, q);
    chk("longest read cycles", 26, n);
    chk("read strobe width", 16, n_rd);
    chk("data driver during read", 0, n_bad);
    chk("pins released", 1'b0, pins_claimed);
    slow <= 1'b0;
  endtask

  task t_nobank;
    bus(1, ADDR_CONFIG, 8'h14);
    bus(1, ADDR_TIMING, 8'h00);
    bus(1, ADDR_PAGE, 8'h40);
    mv(1, 1, 16'h0000, 8'h21, 8'h5a);
    chk("no bank write data", 8'h5a, mem_u.mem[16'hff21]);
    chk("no bank high pins", 0, n_hi);
    bus(1, ADDR_PAGE, 8'h00);
    mv(1, 1, 16'h0000, 8'h21, 8'h6b);
    chk("low page on chip", 0, n_claim);
  endtask

  task t_mux;
    mux_mode <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus(1, ADDR_CONFIG, {6'h03, i[1:0]});
      mv(1, 0, 16'h0010 + 16'(i), 8'h00, 8'h80 + 8'(i));
      chk("mux cycles", 7 + 2 * i, n);
      chk("latch high time", i + 1, n_ale);
      chk("latched write", 8'h80 + 8'(i), mem_u.mem[16'h0010 + 16'(i)]);
    end
    mv(0, 0, 16'h0012, 8'h00, 8'h00);
    chk("mux read", 8'h82, q);
    bus(1, ADDR_PAGE, 8'h12);
    mv(1, 1, 16'h0000, 8'h10, 8'h99);
    chk("off-only short write", 8'h99, mem_u.mem[16'hff10]);
    chk("off-only high pins", 0, n_hi);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_onchip();
    t_bank();
    t_nobank();
    t_mux();
    print_verdict();
  end
endmodule
